// ===== bench/pgsr_host_model.sv
// Host-side model issuing register writes and reads on the strobe bus
`timescale 1ns/1ps
module pgsr_host_model (
   input  wire logic       clk_sys,
   output      logic       reg_wr,
   output      logic       reg_rd,
   output      logic [7:0] reg_addr,
   output      logic [7:0] reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   initial begin
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
   end

   task automatic wr(input logic [7:0] addr, input logic [7:0] data);
      @(negedge clk_sys);
      reg_wr    = 1'b1;
      reg_addr  = addr;
      reg_wdata = data;
      @(negedge clk_sys);
      reg_wr    = 1'b0;
      // Stale data is inverted so nothing can latch it by accident
      reg_wdata = ~data;
   endtask : wr

   // Data stays unknown when no answer arrives within four cycles
   task automatic rd(input logic [7:0] addr, output logic [7:0] data);
      int k;
      data = 8'hxx;
      @(negedge clk_sys);
      reg_rd   = 1'b1;
      reg_addr = addr;
      for (k = 0; k < 4; k++) begin
         @(negedge clk_sys);
         reg_rd = 1'b0;
         if (reg_rvalid === 1'b1) begin
            data = reg_rdata;
            break;
         end
      end
   endtask : rd
endmodule : pgsr_host_model

// ===== bench/pgsr_regs_bench.sv
// Self-checking bench for the power-good sequencer register bank
`timescale 1ns/1ps
module pgsr_regs_bench;
   localparam int DLY = 10;
   localparam logic [7:0] ADR [11] = '{8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1b, 8'h20, 8'h21, 8'h22, 8'h23, 8'h1a};
   localparam logic [7:0] RV  [11] = '{8'h33, 8'h42, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
   localparam logic [7:0] MK  [11] = '{8'h33, 8'h7f, 8'h33, 8'hdf, 8'h3f, 8'h3f, 8'hff, 8'hff, 8'hff, 8'hff, 8'h00};
   localparam int         PER [4]  = '{67, 134, 267, 534};
   logic                  clk_sys, reset, clk_en, reg_wr, reg_rd, reg_rvalid, power_good_pin, tick;
   logic [7:0]            reg_addr, reg_wdata, reg_rdata, b1_code, b2_code;
   logic [12:0]           b1_mv, b2_mv;
   logic [3:0]            discharge_en;
   logic [2:0]            s1, s2, s3, s4;
   pgsr_pkg::pgsr_good_t  good;
   pgsr_pkg::pgsr_onoff_t onoff;
   int                    bad_count, n_compared;

   pgsr_regs #(.DELAY_BASE_CYC(DLY)) i_pgsr_regs (
      .clk_sys(clk_sys), .reset(reset), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .good_async(good), .onoff_async(onoff), .discharge_en(discharge_en), .power_good_pin(power_good_pin),
      .buck1_target_code(b1_code), .buck2_target_code(b2_code), .buck1_target_mv(b1_mv),
      .buck2_target_mv(b2_mv), .scaling_step_tick(tick), .buck1_start_slot(s1), .buck2_start_slot(s2),
      .linreg3_start_slot(s3), .linreg4_start_slot(s4));
   pgsr_host_model i_pgsr_host_model (
      .clk_sys(clk_sys), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

   task automatic conclude;
      if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : conclude

   task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         bad_count++;
         $display("[ERR] %0t value %h expected %h", $time, got, exp);
      end
   endtask : chk_val

   task automatic chk_cnt(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         bad_count++;
         $display("[ERR] %0t count %0d expected %0d", $time, got, exp);
      end
   endtask : chk_cnt

   task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
      logic [7:0] d;
      i_pgsr_host_model.rd(addr, d);
      chk_val({8'h00, d}, {8'h00, exp});
   endtask : rd_chk

   // Pin must first show exp no sooner than lo cycles and no later than hi
   task automatic wait_pin(input logic exp, input int lo, input int hi);
      int k, first;
      first = 0;
      for (k = 1; k <= hi; k++) begin
         @(negedge clk_sys);
         if (first == 0 && power_good_pin === exp) first = k;
      end
      chk_cnt(int'(first >= lo), 1);
   endtask : wait_pin

   task automatic hold_pin(input logic exp, input int n);
      int k, miss;
      miss = 0;
      for (k = 0; k < n; k++) begin
         @(negedge clk_sys);
         if (power_good_pin !== exp) miss++;
      end
      chk_cnt(miss, 0);
   endtask : hold_pin

   task automatic t_reset_vals;
      for (int i = 0; i < 11; i++) rd_chk(ADR[i], RV[i]);
      chk_val({12'h000, discharge_en}, 16'h000f);
   endtask : t_reset_vals

   task automatic t_pin;
      wait_pin(1'b1, 1, 8);
      good.buck1_good = 1'b0;
      hold_pin(1'b1, 10);
      good.buck1_good = 1'b1;
      good.buck2_good = 1'b0;
      wait_pin(1'b0, 1, 6);
      good.buck2_good = 1'b1;
      wait_pin(1'b1, 1, 8);
      good.internal_reset_done = 1'b0;
      wait_pin(1'b0, 1, 6);
      i_pgsr_host_model.wr(8'h16, 8'h02);
      wait_pin(1'b1, 1, 10);
      good.internal_reset_done = 1'b1;
      i_pgsr_host_model.wr(8'h16, 8'h06);
      good.buck1_settled = 1'b0;
      wait_pin(1'b0, 1, 6);
      i_pgsr_host_model.wr(8'h16, 8'h02);
      wait_pin(1'b1, 1, 10);
      good.buck1_settled = 1'b1;
      onoff.lin3_on = 1'b0;
      hold_pin(1'b1, 10);
      i_pgsr_host_model.wr(8'h17, 8'h12);
      wait_pin(1'b0, 1, 6);
      onoff.lin3_on = 1'b1;
      wait_pin(1'b1, 1, 8);
      for (int n = 1; n < 8; n++) begin
         i_pgsr_host_model.wr(8'h18, 8'(n));
         good.buck2_good = 1'b0;
         wait_pin(1'b0, 1, 6);
         good.buck2_good = 1'b1;
         wait_pin(1'b1, DLY << (n - 1), (DLY << (n - 1)) + 8);
      end
   endtask : t_pin

   task automatic t_voltage;
      i_pgsr_host_model.wr(8'h20, 8'hd6);
      i_pgsr_host_model.wr(8'h21, 8'hd8);
      i_pgsr_host_model.wr(8'h22, 8'h02);
      i_pgsr_host_model.wr(8'h23, 8'hff);
      i_pgsr_host_model.wr(8'h18, 8'h00);
      chk_val({8'h00, b1_code, 3'b000, b1_mv}, {8'h00, 8'hd6, 16'd3275});
      chk_val({8'h00, b2_code, 3'b000, b2_mv}, {8'h00, 8'h02, 16'd625});
      i_pgsr_host_model.wr(8'h18, 8'h40);
      chk_val({8'h00, b1_code, 3'b000, b1_mv}, {8'h00, 8'hd8, 16'd3300});
      chk_val({8'h00, b2_code}, 16'h0002);
      i_pgsr_host_model.wr(8'h18, 8'h80);
      chk_val({8'h00, b1_code}, 16'h00d6);
      chk_val({8'h00, b2_code, 3'b000, b2_mv}, {8'h00, 8'hff, 16'd3300});
   endtask : t_voltage

   task automatic t_slots;
      i_pgsr_host_model.wr(8'h19, 8'h3d);
      i_pgsr_host_model.wr(8'h1b, 8'h08);
      chk_val({4'h0, s4, s3, s2, s1}, {4'h0, 3'd1, 3'd0, 3'd7, 3'd5});
   endtask : t_slots

   task automatic next_tick(output int n);
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
      end while (tick !== 1'b1 && n < 1200);
   endtask : next_tick

   task automatic t_step;
      int n;
      for (int c = 0; c < 4; c++) begin
         i_pgsr_host_model.wr(8'h18, {3'b000, 2'(c), 3'b000});
         // The first interval may be partial: the counter keeps its count when the period changes
         next_tick(n);
         next_tick(n);
         next_tick(n);
         chk_cnt(n, PER[c]);
      end
   endtask : t_step

   task automatic t_spare;
      for (int i = 0; i < 11; i++) begin
         i_pgsr_host_model.wr(ADR[i], 8'hff);
         rd_chk(ADR[i], MK[i]);
      end
      i_pgsr_host_model.wr(8'h15, 8'h10);
      chk_val({12'h000, discharge_en}, 16'h0004);
      clk_en = 1'b0;
      i_pgsr_host_model.wr(8'h15, 8'h33);
      clk_en = 1'b1;
      rd_chk(8'h15, 8'h10);
   endtask : t_spare

   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (30000) @(posedge clk_sys);
      bad_count++;
      conclude();
   end

   initial begin
      reset      = 1'b1;
      clk_en     = 1'b1;
      good       = '1;
      onoff      = '1;
      bad_count  = 0;
      n_compared = 0;
      repeat (3) @(negedge clk_sys);
      reset = 1'b0;
      t_reset_vals();
      t_pin();
      t_voltage();
      t_slots();
      t_step();
      t_spare();
      reset = 1'b1;
      repeat (3) @(negedge clk_sys);
      chk_val({15'h0000, power_good_pin}, 16'h0000);
      reset = 1'b0;
      t_reset_vals();
      conclude();
   end
endmodule : pgsr_regs_bench

// ===== common/pgsr_pkg.sv
// Package for the power-good sequencer register bank: map, fields, resets, timing
package pgsr_pkg;
   localparam logic [7:0] ADDR_DISCHARGE = 8'h15;
   localparam logic [7:0] ADDR_PG_ASSIGN = 8'h16;
   localparam logic [7:0] ADDR_PG_GATE   = 8'h17;
   localparam logic [7:0] ADDR_TIMING    = 8'h18;
   localparam logic [7:0] ADDR_BUCK_SEQ  = 8'h19;
   localparam logic [7:0] ADDR_LIN_SEQ   = 8'h1b;
   localparam logic [7:0] ADDR_B1_PROG   = 8'h20;
   localparam logic [7:0] ADDR_B1_SCALED = 8'h21;
   localparam logic [7:0] ADDR_B2_PROG   = 8'h22;
   localparam logic [7:0] ADDR_B2_SCALED = 8'h23;

   localparam logic [7:0] RST_DISCHARGE = 8'h33;
   localparam logic [7:0] RST_PG_ASSIGN = 8'h42;
   localparam logic [7:0] RST_PG_GATE   = 8'h02;
   localparam logic [7:0] RST_TIMING    = 8'h00;
   localparam logic [7:0] RST_SEQ       = 8'h00;
   localparam logic [7:0] RST_VOLT      = 8'h00;

   // Writable masks; zero positions are spare
   localparam logic [7:0] MASK_DISCHARGE = 8'h33;
   localparam logic [7:0] MASK_PG_ASSIGN = 8'h7f;
   localparam logic [7:0] MASK_PG_GATE   = 8'h33;
   localparam logic [7:0] MASK_TIMING    = 8'hdf;
   localparam logic [7:0] MASK_SEQ       = 8'h3f;

   localparam int BIT_BUCK1   = 0;
   localparam int BIT_BUCK2   = 1;
   localparam int BIT_SCALE1  = 2;
   localparam int BIT_SCALE2  = 3;
   localparam int BIT_LIN3    = 4;
   localparam int BIT_LIN4    = 5;
   localparam int BIT_RSTASGN = 6;
   localparam int BIT_SEL1    = 6;
   localparam int BIT_SEL2    = 7;
   localparam int POS_DELAY   = 0;
   localparam int POS_STEP    = 3;
   localparam int POS_SLOT_HI = 3;

   localparam int CLK_HZ         = 50000000;
   localparam int DELAY_BASE_MS  = 8;
   localparam int DELAY_BASE_CYC = DELAY_BASE_MS * (CLK_HZ / 1000);
   localparam int STEP_NS_0      = 1330;
   localparam int STEP_NS_1      = 2670;
   localparam int STEP_NS_2      = 5330;
   localparam int STEP_NS_3      = 10670;
   localparam int CLK_NS         = 1000000000 / CLK_HZ;
   localparam logic [9:0] STEP_CYC_0 = 10'((STEP_NS_0 + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] STEP_CYC_1 = 10'((STEP_NS_1 + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] STEP_CYC_2 = 10'((STEP_NS_2 + CLK_NS - 1) / CLK_NS);
   localparam logic [9:0] STEP_CYC_3 = 10'((STEP_NS_3 + CLK_NS - 1) / CLK_NS);

   localparam int        MV_BASE    = 600;
   localparam int        MV_STEP_UV = 12500;
   localparam logic [7:0] CODE_SAT  = 8'hd8;

   // Sources of the power-good pin as seen from the analog side
   typedef struct packed {
      logic       buck1_good;
      logic       buck2_good;
      logic       buck1_settled;
      logic       buck2_settled;
      logic       lin3_good;
      logic       lin4_good;
      logic       internal_reset_done;
   } pgsr_good_t;

   typedef struct packed {
      logic       buck1_on;
      logic       buck2_on;
      logic       lin3_on;
      logic       lin4_on;
   } pgsr_onoff_t;

   typedef enum logic [2:0] {
      PGSR_IN_RESET = 3'b001,
      PGSR_DELAY    = 3'b010,
      PGSR_RELEASED = 3'b100
   } pgsr_state_t;
endpackage : pgsr_pkg

// ===== rtl/pgsr_regs.sv
// Power-good sequencer register bank with pin logic and scaling step timer
`timescale 1ns/1ps
module pgsr_regs #(
   parameter int DELAY_BASE_CYC = pgsr_pkg::DELAY_BASE_CYC
) (
   input  wire logic                 clk_sys,
   input  wire logic                 reset,
   input  wire logic                 clk_en,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   input  wire logic [7:0]           reg_addr,
   input  wire logic [7:0]           reg_wdata,
   output      logic [7:0]           reg_rdata,
   output      logic                 reg_rvalid,
   input  wire pgsr_pkg::pgsr_good_t good_async,
   input  wire pgsr_pkg::pgsr_onoff_t onoff_async,
   output      logic [3:0]           discharge_en,
   output      logic                 power_good_pin,
   output      logic [7:0]           buck1_target_code,
   output      logic [7:0]           buck2_target_code,
   output      logic [12:0]          buck1_target_mv,
   output      logic [12:0]          buck2_target_mv,
   output      logic                 scaling_step_tick,
   output      logic [2:0]           buck1_start_slot,
   output      logic [2:0]           buck2_start_slot,
   output      logic [2:0]           linreg3_start_slot,
   output      logic [2:0]           linreg4_start_slot
);
   function automatic logic [12:0] code_to_mv(input logic [7:0] code);
      logic [7:0]  c;
      logic [21:0] uv;
      c  = (code >= pgsr_pkg::CODE_SAT) ? pgsr_pkg::CODE_SAT : code;
      // Product reaches 2.7 million at saturation, so 22 bits are needed
      uv = 22'(c) * 22'(pgsr_pkg::MV_STEP_UV);
      return 13'(pgsr_pkg::MV_BASE) + 13'(uv / 22'd1000);
   endfunction : code_to_mv

   logic [7:0] dis_reg, asg_reg, gate_reg, tim_reg, bseq_reg, lseq_reg;
   logic [7:0] b1p_reg, b1s_reg, b2p_reg, b2s_reg;
   logic [6:0] good_s1_reg, good_s2_reg;
   logic [3:0] on_s1_reg, on_s2_reg;
   pgsr_pkg::pgsr_state_t state_reg, state_next;
   logic [31:0] dly_cnt_reg;
   logic [9:0]  step_cnt_reg;
   logic        pg_reg;

   // Pin-side inputs pass two flops before use
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         good_s1_reg <= '0;
         good_s2_reg <= '0;
         on_s1_reg   <= '0;
         on_s2_reg   <= '0;
      end else if (clk_en) begin
         good_s1_reg <= good_async;
         good_s2_reg <= good_s1_reg;
         on_s1_reg   <= onoff_async;
         on_s2_reg   <= on_s1_reg;
      end
   end

   wire pgsr_pkg::pgsr_good_t  good_s = good_s2_reg;
   wire pgsr_pkg::pgsr_onoff_t on_s   = on_s2_reg;

   // Register writes; spare bits masked off
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         dis_reg  <= pgsr_pkg::RST_DISCHARGE;
         asg_reg  <= pgsr_pkg::RST_PG_ASSIGN;
         gate_reg <= pgsr_pkg::RST_PG_GATE;
         tim_reg  <= pgsr_pkg::RST_TIMING;
         bseq_reg <= pgsr_pkg::RST_SEQ;
         lseq_reg <= pgsr_pkg::RST_SEQ;
         b1p_reg  <= pgsr_pkg::RST_VOLT;
         b1s_reg  <= pgsr_pkg::RST_VOLT;
         b2p_reg  <= pgsr_pkg::RST_VOLT;
         b2s_reg  <= pgsr_pkg::RST_VOLT;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            pgsr_pkg::ADDR_DISCHARGE: dis_reg  <= reg_wdata & pgsr_pkg::MASK_DISCHARGE;
            pgsr_pkg::ADDR_PG_ASSIGN: asg_reg  <= reg_wdata & pgsr_pkg::MASK_PG_ASSIGN;
            pgsr_pkg::ADDR_PG_GATE:   gate_reg <= reg_wdata & pgsr_pkg::MASK_PG_GATE;
            pgsr_pkg::ADDR_TIMING:    tim_reg  <= reg_wdata & pgsr_pkg::MASK_TIMING;
            pgsr_pkg::ADDR_BUCK_SEQ:  bseq_reg <= reg_wdata & pgsr_pkg::MASK_SEQ;
            pgsr_pkg::ADDR_LIN_SEQ:   lseq_reg <= reg_wdata & pgsr_pkg::MASK_SEQ;
            pgsr_pkg::ADDR_B1_PROG:   b1p_reg  <= reg_wdata;
            pgsr_pkg::ADDR_B1_SCALED: b1s_reg  <= reg_wdata;
            pgsr_pkg::ADDR_B2_PROG:   b2p_reg  <= reg_wdata;
            pgsr_pkg::ADDR_B2_SCALED: b2s_reg  <= reg_wdata;
            default: ;
         endcase
      end
   end

   wire [7:0] rd_mux =
      (reg_addr == pgsr_pkg::ADDR_DISCHARGE) ? dis_reg  :
      (reg_addr == pgsr_pkg::ADDR_PG_ASSIGN) ? asg_reg  :
      (reg_addr == pgsr_pkg::ADDR_PG_GATE)   ? gate_reg :
      (reg_addr == pgsr_pkg::ADDR_TIMING)    ? tim_reg  :
      (reg_addr == pgsr_pkg::ADDR_BUCK_SEQ)  ? bseq_reg :
      (reg_addr == pgsr_pkg::ADDR_LIN_SEQ)   ? lseq_reg :
      (reg_addr == pgsr_pkg::ADDR_B1_PROG)   ? b1p_reg  :
      (reg_addr == pgsr_pkg::ADDR_B1_SCALED) ? b1s_reg  :
      (reg_addr == pgsr_pkg::ADDR_B2_PROG)   ? b2p_reg  :
      (reg_addr == pgsr_pkg::ADDR_B2_SCALED) ? b2s_reg  : 8'h00;

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         reg_rdata  <= 8'h00;
         reg_rvalid <= 1'b0;
      end else if (clk_en) begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            reg_rdata <= rd_mux;
         end
      end
   end

   // Discharge and start slots straight from the registers
   assign discharge_en = {dis_reg[5], dis_reg[4], dis_reg[1], dis_reg[0]};
   assign buck1_start_slot   = bseq_reg[2:0];
   assign buck2_start_slot   = bseq_reg[pgsr_pkg::POS_SLOT_HI +: 3];
   assign linreg3_start_slot = lseq_reg[2:0];
   assign linreg4_start_slot = lseq_reg[pgsr_pkg::POS_SLOT_HI +: 3];

   // Target voltage selection
   wire sel1 = tim_reg[pgsr_pkg::BIT_SEL1];
   wire sel2 = tim_reg[pgsr_pkg::BIT_SEL2];
   assign buck1_target_code = sel1 ? b1s_reg : b1p_reg;
   assign buck2_target_code = sel2 ? b2s_reg : b2p_reg;
   assign buck1_target_mv   = code_to_mv(buck1_target_code);
   assign buck2_target_mv   = code_to_mv(buck2_target_code);

   // Power-good combination: unassigned sources count as good
   wire src_ok =
      (!asg_reg[pgsr_pkg::BIT_BUCK1]   || good_s.buck1_good)    &&
      (!asg_reg[pgsr_pkg::BIT_BUCK2]   || good_s.buck2_good)    &&
      (!asg_reg[pgsr_pkg::BIT_LIN3]    || good_s.lin3_good)     &&
      (!asg_reg[pgsr_pkg::BIT_LIN4]    || good_s.lin4_good)     &&
      (!asg_reg[pgsr_pkg::BIT_SCALE1]  || good_s.buck1_settled) &&
      (!asg_reg[pgsr_pkg::BIT_SCALE2]  || good_s.buck2_settled);
   wire rst_ok  = !asg_reg[pgsr_pkg::BIT_RSTASGN] || good_s.internal_reset_done;
   wire gate_ok =
      (!gate_reg[0] || on_s.buck1_on) && (!gate_reg[1] || on_s.buck2_on) &&
      (!gate_reg[4] || on_s.lin3_on)  && (!gate_reg[5] || on_s.lin4_on);
   wire all_ok  = src_ok && rst_ok && gate_ok;

   // Release delay: 0 for code 0, else base shifted by code-1
   wire [2:0]  dly_code   = tim_reg[pgsr_pkg::POS_DELAY +: 3];
   wire [31:0] dly_target = (dly_code == 3'd0) ? 32'd0 :
                            (32'(DELAY_BASE_CYC) << (dly_code - 3'd1));
   wire        dly_done   = (dly_cnt_reg >= dly_target);

   always_comb begin
      case (state_reg)
         pgsr_pkg::PGSR_IN_RESET: state_next = all_ok ? pgsr_pkg::PGSR_DELAY : pgsr_pkg::PGSR_IN_RESET;
         pgsr_pkg::PGSR_DELAY:    state_next = !all_ok ? pgsr_pkg::PGSR_IN_RESET :
                                               dly_done ? pgsr_pkg::PGSR_RELEASED : pgsr_pkg::PGSR_DELAY;
         pgsr_pkg::PGSR_RELEASED: state_next = all_ok ? pgsr_pkg::PGSR_RELEASED : pgsr_pkg::PGSR_IN_RESET;
         default:                 state_next = pgsr_pkg::PGSR_IN_RESET;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         state_reg   <= pgsr_pkg::PGSR_IN_RESET;
         dly_cnt_reg <= '0;
         pg_reg      <= 1'b0;
      end else if (clk_en) begin
         state_reg   <= state_next;
         dly_cnt_reg <= (state_reg == pgsr_pkg::PGSR_DELAY) ? dly_cnt_reg + 32'd1 : 32'd0;
         pg_reg      <= (state_next == pgsr_pkg::PGSR_RELEASED);
      end
   end
   assign power_good_pin = pg_reg;

   // Scaling step timer; one tick per step period
   wire [1:0] step_code = tim_reg[pgsr_pkg::POS_STEP +: 2];
   wire [9:0] step_len  = (step_code == 2'd0) ? pgsr_pkg::STEP_CYC_0 :
                          (step_code == 2'd1) ? pgsr_pkg::STEP_CYC_1 :
                          (step_code == 2'd2) ? pgsr_pkg::STEP_CYC_2 : pgsr_pkg::STEP_CYC_3;
   wire       step_end  = (step_cnt_reg >= step_len - 10'd1);

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         step_cnt_reg      <= '0;
         scaling_step_tick <= 1'b0;
      end else if (clk_en) begin
         step_cnt_reg      <= step_end ? 10'd0 : step_cnt_reg + 10'd1;
         scaling_step_tick <= step_end;
      end
   end

   property p_pg_needs_ok;
      @(posedge clk_sys) disable iff (reset)
      clk_en && !all_ok |=> !power_good_pin;
   endproperty
   a_pg_needs_ok: assert property (p_pg_needs_ok) else $error("pin good while a source is bad");

   property p_discharge;
      @(posedge clk_sys) disable iff (reset)
      clk_en && reg_wr && reg_addr == pgsr_pkg::ADDR_DISCHARGE
      |=> discharge_en == {$past(reg_wdata[5:4]), $past(reg_wdata[1:0])} && dis_reg[7:6] == 2'b00;
   endproperty
   a_discharge: assert property (p_discharge) else $error("discharge enable mismatch");

   property p_assign_gate;
      @(posedge clk_sys) disable iff (reset)
      clk_en && asg_reg[pgsr_pkg::BIT_BUCK2] && !good_s.buck2_good |=> !power_good_pin;
   endproperty
   a_assign_gate: assert property (p_assign_gate) else $error("assigned buck two ignored");

   property p_scale_assign;
      @(posedge clk_sys) disable iff (reset)
      clk_en && asg_reg[pgsr_pkg::BIT_SCALE1] && !good_s.buck1_settled |=> !power_good_pin;
   endproperty
   a_scale_assign: assert property (p_scale_assign) else $error("scaling state ignored");

   property p_rst_assign;
      @(posedge clk_sys) disable iff (reset)
      clk_en && asg_reg[pgsr_pkg::BIT_RSTASGN] && !good_s.internal_reset_done |=> !power_good_pin;
   endproperty
   a_rst_assign: assert property (p_rst_assign) else $error("internal reset ignored");

   property p_gate;
      @(posedge clk_sys) disable iff (reset)
      clk_en && gate_reg[1] && !on_s.buck2_on |=> !power_good_pin;
   endproperty
   a_gate: assert property (p_gate) else $error("gating output off but pin good");

   sequence s_ok_run;
      (clk_en && all_ok && dly_code == 3'd0) [*3];
   endsequence
   property p_zero_delay;
      @(posedge clk_sys) disable iff (reset)
      s_ok_run |=> power_good_pin;
   endproperty
   a_zero_delay: assert property (p_zero_delay) else $error("zero delay release late");

   property p_step_tick;
      @(posedge clk_sys) disable iff (reset)
      clk_en && step_code == 2'd0 && step_cnt_reg == pgsr_pkg::STEP_CYC_0 - 10'd1
      |=> scaling_step_tick && step_cnt_reg == 10'd0;
   endproperty
   a_step_tick: assert property (p_step_tick) else $error("step period wrong");

   property p_sel;
      @(posedge clk_sys) disable iff (reset)
      buck1_target_code == (tim_reg[6] ? b1s_reg : b1p_reg) &&
      buck2_target_code == (tim_reg[7] ? b2s_reg : b2p_reg);
   endproperty
   a_sel: assert property (p_sel) else $error("target select wrong");

   property p_sat;
      @(posedge clk_sys) disable iff (reset)
      buck1_target_code >= 8'hd8 |-> buck1_target_mv == 13'd3300;
   endproperty
   a_sat: assert property (p_sat) else $error("saturation wrong");

   property p_spare;
      @(posedge clk_sys) disable iff (reset)
      tim_reg[5] == 1'b0 && asg_reg[7] == 1'b0 && bseq_reg[7:6] == 2'b00;
   endproperty
   a_spare: assert property (p_spare) else $error("spare bit set");

   property p_slot;
      @(posedge clk_sys) disable iff (reset)
      buck2_start_slot == bseq_reg[5:3] && linreg4_start_slot == lseq_reg[5:3];
   endproperty
   a_slot: assert property (p_slot) else $error("start slot mismatch");

   property p_read_answer;
      @(posedge clk_sys) disable iff (reset)
      clk_en && reg_rd |=> reg_rvalid && reg_rdata == $past(rd_mux);
   endproperty
   a_read_answer: assert property (p_read_answer) else $error("read answer wrong");

   property p_hold_delay;
      @(posedge clk_sys) disable iff (reset)
      clk_en && state_reg == pgsr_pkg::PGSR_DELAY && !dly_done |=> !power_good_pin;
   endproperty
   a_hold_delay: assert property (p_hold_delay) else $error("pin released before delay");

   // A loss while released must keep the pin low for the next two cycles
   sequence s_released;
      clk_en && power_good_pin;
   endsequence
   sequence s_source_lost;
      clk_en && !all_ok;
   endsequence
   property p_drop;
      @(posedge clk_sys) disable iff (reset)
      s_released ##0 s_source_lost |=> !power_good_pin [*2];
   endproperty
   a_drop: assert property (p_drop) else $error("pin did not drop on loss");

   property p_tick_pulse;
      @(posedge clk_sys) disable iff (reset)
      clk_en && scaling_step_tick |=> !scaling_step_tick;
   endproperty
   a_tick_pulse: assert property (p_tick_pulse) else $error("step tick longer than one cycle");

   property p_mv_linear;
      @(posedge clk_sys) disable iff (reset)
      buck2_target_code < pgsr_pkg::CODE_SAT
      |-> buck2_target_mv == 13'(pgsr_pkg::MV_BASE) + ({5'd0, buck2_target_code} * 13'd25) / 13'd2;
   endproperty
   a_mv_linear: assert property (p_mv_linear) else $error("voltage decode wrong");
endmodule : pgsr_regs
